// ===== logic/timer0_shared_prescaler.v
// Behaviour
// R1 - Select field picks stop, undivided, prescaler taps
// R2 - Codes 6/7 count falling/rising pin edges
// R3 - Pin counts even when driven as output
// R4 - Counter read/write; control upper bits zero
// R5 - Mask bit 0 enables overflow interrupt
// R6 - Flag set on overflow, cleared on vector
// R7 - Writing one clears flag, zero ignored
// R8 - Prescaler free running, shared by timers
// R9 - First prescaled tick within 1..N+1 cycles
// R10 - Prescaler reset restarts all timers' periods
// R11 - Pin sampled every cycle, then edge detected
// R12 - Latch on high phase, then rising registers
// R13 - One tick per selected edge
// R14 - Pin edge to count 2.5..3.5 cycles
// R15 - Software toggles ext clock when pin stable
// R16 - External half period exceeds one cycle
// R17 - External ticks bypass the prescaler
// R18 - Prescaler reset bit self clears
// R19 - Reset bit write zero ignored, reads zero
// R20 - Counts up only, wraps to zero
// R21 - Flag set with counter reaching zero
// R22 - CPU counter write beats counting
// R23 - Tick is single-cycle enable
// R24 - Irq output is flag and enable
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`include "timer0_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module timer0_shared_prescaler #(
  parameter CNT_W = 8
) (
  input wire clk,
  input wire srst,
  input wire [`ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire ext_count_pin,
  input wire irq_vector_ack,
  output wire overflow_irq,
  output wire [3:0] prescaler_taps
);
  // Register state
  reg [`CS_W-1:0] clock_select_field_r;
  reg [`CS_W-1:0] clock_select_field_nxt;
  reg [CNT_W-1:0] counter_value_r;
  reg [CNT_W-1:0] counter_value_nxt;
  reg overflow_irq_enable_r;
  reg overflow_irq_enable_nxt;
  reg overflow_flag_r;
  reg overflow_flag_nxt;
  reg prescaler_reset_bit_r;
  reg prescaler_reset_bit_nxt;
  reg [`PRE_W-1:0] presc_r;
  reg [`PRE_W-1:0] presc_nxt;
  reg [`PRE_W-1:0] presc_d_r;
  reg [`PRE_W-1:0] presc_d_nxt;
  reg [`DATA_W-1:0] readdata_nxt;

  // Pin sampling chain
  reg pin_latch_r;
  reg pin_s1_r;
  reg pin_s2_r;
  reg pin_prev_r;
  wire pin_rise;
  wire pin_fall;

  // Bus handshake and decode
  reg ack_r;
  reg ack_nxt;
  wire bus_req;
  wire wr_done;
  wire rd_first;
  wire sel_ctrl;
  wire sel_count;
  wire sel_mask;
  wire sel_flags;
  wire wr_ctrl;
  wire wr_count;
  wire wr_mask;
  wire wr_flags;
  wire wr_sfr;
  reg [`DATA_W-1:0] rd_mux;

  // Tick source and overflow
  reg timer_tick;
  wire [CNT_W-1:0] cnt_inc;
  wire [CNT_W-1:0] all_ones;
  wire cnt_at_max;
  wire ovf_set;
  wire ovf_clear;
  wire [`N_TAPS-1:0] tap_now;
  wire [`N_TAPS-1:0] tap_was;
  genvar g;

  // One wait cycle: waitrequest drops in the second cycle of a request
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign wr_done = avs_write & ack_r;
  assign rd_first = avs_read & ~ack_r;

  // A held request restarts the handshake after each completion
  always @* begin
    ack_nxt = bus_req & ~ack_r;
  end

  always @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // Address decode; unmapped writes fall through harmlessly
  assign sel_ctrl = (avs_address == `OFS_CTRL);
  assign sel_count = (avs_address == `OFS_COUNT);
  assign sel_mask = (avs_address == `OFS_MASK);
  assign sel_flags = (avs_address == `OFS_FLAGS);

  // Write strobes only in the completing cycle
  assign wr_ctrl = wr_done & sel_ctrl;
  assign wr_count = wr_done & sel_count;
  assign wr_mask = wr_done & sel_mask;
  assign wr_flags = wr_done & sel_flags;

  // Prescaler reset rides in the control word, outside the select field
  assign wr_sfr = wr_ctrl & avs_writedata[`BIT_PSR];

  // Reset strobe lives one cycle, then clears itself
  always @* begin
    prescaler_reset_bit_nxt = wr_sfr; // R18 R19
  end

  always @(posedge clk) begin
    if (srst) begin
      prescaler_reset_bit_r <= 1'b0;
    end else begin
      prescaler_reset_bit_r <= prescaler_reset_bit_nxt;
    end
  end

  // Free running; only srst or its reset bit restarts it, never a select change
  always @* begin
    presc_nxt = presc_r + {{(`PRE_W-1){1'b0}}, 1'b1}; // R8
    if (prescaler_reset_bit_r) begin
      presc_nxt = {`PRE_W{1'b0}}; // R10
    end
  end

  // Delayed copy cleared too, so a reset never fakes a tap
  always @* begin
    presc_d_nxt = presc_r;
    if (prescaler_reset_bit_r) begin
      presc_d_nxt = {`PRE_W{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      presc_r <= {`PRE_W{1'b0}};
    end else begin
      presc_r <= presc_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      presc_d_r <= {`PRE_W{1'b0}};
    end else begin
      presc_d_r <= presc_d_nxt;
    end
  end

  // Falling tap bits line up, so every slower tap coincides with /8
  assign tap_now = {presc_r[`TAP1024],
                    presc_r[`TAP256],
                    presc_r[`TAP64],
                    presc_r[`TAP8]};
  assign tap_was = {presc_d_r[`TAP1024],
                    presc_d_r[`TAP256],
                    presc_d_r[`TAP64],
                    presc_d_r[`TAP8]};

  generate
    for (g = 0; g < `N_TAPS; g = g + 1) begin : tap_gen
      // Phase is kept across enables, so the first tick may come early
      assign prescaler_taps[g] = tap_was[g] & ~tap_now[g]; // R9
    end
  endgenerate

  // Falling-edge flop stands in for the latch open while clk is high
  always @(negedge clk) begin
    if (srst) begin
      pin_latch_r <= 1'b0;
    end else begin
      pin_latch_r <= ext_count_pin; // R12
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pin_s1_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_latch_r; // R11
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pin_s2_r <= 1'b0;
    end else begin
      pin_s2_r <= pin_s1_r;
    end
  end

  // Edge detector history; only the second stage is read by logic
  always @(posedge clk) begin
    if (srst) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_s2_r;
    end
  end

  // Reset low matches an idle low pin; a high idle pin fakes one rise
  assign pin_rise = pin_s2_r & ~pin_prev_r;
  assign pin_fall = pin_prev_r & ~pin_s2_r;

  // Pin direction is not consulted, so a driven pin still counts
  always @* begin
    case (clock_select_field_r) // R1
      `CS_STOP: begin
        timer_tick = 1'b0;
      end
      `CS_DIV1: begin
        timer_tick = 1'b1;
      end
      `CS_DIV8: begin
        timer_tick = prescaler_taps[0];
      end
      `CS_DIV64: begin
        timer_tick = prescaler_taps[1];
      end
      `CS_DIV256: begin
        timer_tick = prescaler_taps[2];
      end
      `CS_DIV1024: begin
        timer_tick = prescaler_taps[3];
      end
      `CS_EXT_FALL: begin
        timer_tick = pin_fall; // R2 R3 R13 R17
      end
      `CS_EXT_RISE: begin
        timer_tick = pin_rise; // R2 R13 R14
      end
      default: begin
        timer_tick = 1'b0;
      end
    endcase
  end

  always @* begin
    clock_select_field_nxt = clock_select_field_r;
    if (wr_ctrl) begin
      clock_select_field_nxt = avs_writedata[`CS_HI:`CS_LO]; // R1
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      clock_select_field_r <= `CS_STOP; // R4
    end else begin
      clock_select_field_r <= clock_select_field_nxt;
    end
  end

  assign cnt_inc = counter_value_r + {{(CNT_W-1){1'b0}}, 1'b1};
  assign all_ones = {CNT_W{1'b1}};
  assign cnt_at_max = (counter_value_r == all_ones);

  // A bus write wins over a tick landing in the same cycle
  always @* begin
    counter_value_nxt = counter_value_r;
    if (wr_count) begin
      counter_value_nxt = avs_writedata[CNT_W-1:0]; // R22 R4
    end else if (timer_tick) begin
      counter_value_nxt = cnt_inc; // R20 R23
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      counter_value_r <= {CNT_W{1'b0}};
    end else begin
      counter_value_r <= counter_value_nxt;
    end
  end

  always @* begin
    overflow_irq_enable_nxt = overflow_irq_enable_r;
    if (wr_mask) begin
      overflow_irq_enable_nxt = avs_writedata[`BIT_OVF]; // R5
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      overflow_irq_enable_r <= 1'b0;
    end else begin
      overflow_irq_enable_r <= overflow_irq_enable_nxt;
    end
  end

  // Overwritten counts raise no flag; a clear in the set cycle loses
  assign ovf_set = timer_tick & ~wr_count & cnt_at_max;
  assign ovf_clear = irq_vector_ack | (wr_flags & avs_writedata[`BIT_OVF]);

  always @* begin
    overflow_flag_nxt = overflow_flag_r;
    if (ovf_set) begin
      overflow_flag_nxt = 1'b1; // R21 R6
    end else if (ovf_clear) begin
      overflow_flag_nxt = 1'b0; // R6 R7
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      overflow_flag_r <= 1'b0;
    end else begin
      overflow_flag_r <= overflow_flag_nxt;
    end
  end

  // Global masking stays with the CPU
  assign overflow_irq = overflow_flag_r & overflow_irq_enable_r; // R24 R5

  // Reset bit and upper control bits never reach the read path
  always @* begin
    if (sel_ctrl) begin
      rd_mux = {{(`DATA_W-`CS_W){1'b0}}, clock_select_field_r}; // R4 R19
    end else if (sel_count) begin
      rd_mux = {{(`DATA_W-CNT_W){1'b0}}, counter_value_r}; // R4
    end else if (sel_mask) begin
      rd_mux = {{(`DATA_W-1){1'b0}}, overflow_irq_enable_r};
    end else if (sel_flags) begin
      rd_mux = {{(`DATA_W-1){1'b0}}, overflow_flag_r};
    end else begin
      rd_mux = `BAD_READ;
    end
  end

  // Captured in the wait cycle so it stands when waitrequest drops
  always @* begin
    readdata_nxt = avs_readdata;
    if (rd_first) begin
      readdata_nxt = rd_mux;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      avs_readdata <= `RD_RESET;
    end else begin
      avs_readdata <= readdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== logic/timer0_defines.vh
`ifndef TIMER0_DEFINES_VH
`define TIMER0_DEFINES_VH
`define ADDR_W 4
`define OFS_CTRL 4'h0
`define OFS_COUNT 4'h4
`define OFS_MASK 4'h8
`define OFS_FLAGS 4'hC
`define CS_LO 0
`define CS_HI 2
`define BIT_OVF 0
`define BIT_PSR 8
`define CS_W 3
`define DATA_W 32
`define RD_RESET 32'h00000000
`define N_TAPS 4
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define TAP8 2
`define TAP64 5
`define TAP256 7
`define TAP1024 9
`define PRE_W 10
`define BAD_READ 32'hDEADBEEF
`endif

// ===== tb/timer0_checker.sv
`timescale 1ns/10ps
`default_nettype none
module timer0_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic overflow_irq,
  input wire logic [3:0] prescaler_taps
);
  logic mask_r;
  // Shadow of the enable, so the irq can be judged from the bus alone
  always @(posedge clk) begin
    if (srst)
      mask_r <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h8)
      mask_r <= avs_writedata[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_wait_idle: assert property (avs_waitrequest |-> avs_read || avs_write)
    else $error("wait unasked");
  a_ctrl_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[31:3] == 29'h0)
    else $error("control upper bits");
  a_bad_read: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'hDEADBEEF)
    else $error("unmapped read");
  a_rd_stable: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("readdata moved");
  a_tap_gap: assert property (prescaler_taps[0] |=> !prescaler_taps[0] [*7])
    else $error("tap spacing");
  a_tap_nest: assert property (prescaler_taps[3] |-> &prescaler_taps[2:0])
    else $error("taps not nested");
  a_irq_masked: assert property (!mask_r |-> !overflow_irq)
    else $error("irq while masked");
endmodule
bind timer0_shared_prescaler timer0_checker chk_u (.*);
`default_nettype wire

// ===== tb/pin_source.sv
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // Ends low and stable, so enabling the clock never sees a false edge
  task pulses(input int n, input int h);
    repeat (n) begin
      @(posedge clk) pin <= 1'b1;
      repeat (h) @(posedge clk);
      pin <= 1'b0;
      repeat (h) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/timer0_shared_prescaler_bench.sv
`timescale 1ns/10ps
`default_nettype none
module timer0_shared_prescaler_bench;
  logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, ack = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic wt, irq, pin;
  int err_total = 0, n_compared = 0;
  int dv[4] = '{8, 64, 256, 1024};
  logic [3:0] offs[4] = '{4'h0, 4'h4, 4'h8, 4'hC};
  always #12.5 clk = ~clk;
  pin_source pin_u (.clk(clk), .pin(pin));
  timer0_shared_prescaler dut_u (.clk(clk), .srst(srst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
    .ext_count_pin(pin), .irq_vector_ack(ack), .overflow_irq(irq), .prescaler_taps());
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wt !== 1'b0 && k < 20);
    if (wt !== 1'b0)
      err_total++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (offs[i]) rc(offs[i], 32'h0);
    rc(4'h2, 32'hDEADBEEF);
    acc(1'b1, 4'h4, 32'hFE);
    repeat (20) @(posedge clk);
    rc(4'h4, 32'hFE);
    $display("test 1 done");
    acc(1'b1, 4'h0, 32'h7);
    pin_u.pulses(3, 2);
    rc(4'h4, 32'h1);
    rc(4'hC, 32'h1);
    acc(1'b1, 4'h0, 32'h6);
    pin_u.pulses(2, 3);
    rc(4'h4, 32'h3);
    acc(1'b1, 4'hC, 32'h0);
    rc(4'hC, 32'h1);
    acc(1'b1, 4'h8, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
    rc(4'hC, 32'h0);
    acc(1'b1, 4'h4, 32'hFF);
    pin_u.pulses(1, 2);
    acc(1'b1, 4'hC, 32'h1);
    rc(4'hC, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test 2 done");
    foreach (dv[i]) begin
      acc(1'b1, 4'h4, 32'h0);
      acc(1'b1, 4'h0, 32'h100 | (i + 2));
      rc(4'h0, i + 2);
      repeat (1024) @(posedge clk);
      acc(1'b1, 4'h0, 32'h0);
      acc(1'b0, 4'h4, 32'h0);
      chk(q > 1024 / dv[i] + 1 || q + 1 < 1024 / dv[i], 32'h0);
    end
    $display("test 3 done");
    test_done;
  end
endmodule
`default_nettype wire
